// *** inc/drp_pkg.sv ***
// Constants and types for the per-reference loop profile register bank.
// Assumes a 32-bit AXI4-Lite master; each byte register sits in one aligned word.
package drp_pkg;

  // Bus widths
  localparam int ADDR_W = 16;                      // Byte address width, covers 4 x 0x044C
  localparam int DATA_W = 32;                      // AXI data width
  localparam int NUM_REGS = 12;                    // Byte registers in the profile

  typedef logic [ADDR_W-1:0] drp_addr_t;           // AXI byte address
  typedef logic [DATA_W-1:0] drp_data_t;           // AXI data word
  typedef logic [13:0]       drp_idx_t;            // Register index (byte address / 4)
  typedef logic [3:0]        drp_loc_t;            // Position inside the profile

  // Register indices as printed; byte address is four times the index
  localparam drp_idx_t IDX_BW_LO   = 14'h0441;     // Loop bandwidth low byte
  localparam drp_idx_t IDX_BW_MID  = 14'h0442;     // Loop bandwidth middle byte
  localparam drp_idx_t IDX_BW_TOP  = 14'h0443;     // Bandwidth bit 16 and filter select
  localparam drp_idx_t IDX_INT_LO  = 14'h0444;     // Integer feedback low byte
  localparam drp_idx_t IDX_INT_MID = 14'h0445;     // Integer feedback middle byte
  localparam drp_idx_t IDX_INT_TOP = 14'h0446;     // Integer feedback bits 17:16
  localparam drp_idx_t IDX_NUM_LO  = 14'h0447;     // Numerator low byte
  localparam drp_idx_t IDX_NUM_MID = 14'h0448;     // Numerator middle byte
  localparam drp_idx_t IDX_NUM_HI  = 14'h0449;     // Numerator high byte
  localparam drp_idx_t IDX_MOD_LO  = 14'h044A;     // Modulus low byte
  localparam drp_idx_t IDX_MOD_MID = 14'h044B;     // Modulus middle byte
  localparam drp_idx_t IDX_MOD_HI  = 14'h044C;     // Modulus high byte

  // Positions inside the profile storage
  localparam drp_loc_t LOC_BW_LO   = 4'h0;
  localparam drp_loc_t LOC_BW_MID  = 4'h1;
  localparam drp_loc_t LOC_BW_TOP  = 4'h2;
  localparam drp_loc_t LOC_INT_LO  = 4'h3;
  localparam drp_loc_t LOC_INT_MID = 4'h4;
  localparam drp_loc_t LOC_INT_TOP = 4'h5;
  localparam drp_loc_t LOC_NUM_LO  = 4'h6;
  localparam drp_loc_t LOC_NUM_MID = 4'h7;
  localparam drp_loc_t LOC_NUM_HI  = 4'h8;
  localparam drp_loc_t LOC_MOD_LO  = 4'h9;
  localparam drp_loc_t LOC_MOD_MID = 4'hA;
  localparam drp_loc_t LOC_MOD_HI  = 4'hB;

  // Field positions and writable masks
  localparam int       BW_BIT16_POS  = 0;          // Bandwidth bit 16 in top byte
  localparam int       FILT_SEL_POS  = 1;          // High phase margin filter select
  localparam logic [7:0] MASK_FULL   = 8'hFF;      // All bits writable
  localparam logic [7:0] MASK_TOP2   = 8'h03;      // Only bits 1:0 writable

  // Reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;     // Every profile byte
  localparam logic [18:0] RST_INT_DIV = 19'h00001; // Divide by one after reset
  localparam logic [18:0] INT_DIV_ONE = 19'h00001; // Stored value is divide minus one

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : drp_pkg

// *** rtl/drp_regs.sv ***
// Profile register bank for one digital loop locking to its first reference.
// Assumes an AXI4-Lite master on ref_clk; one write and one read at a time.
// Assumes software holds the loop while it rewrites multi-byte fields.
// Function
// - Bandwidth is 17 bits from three bytes.
// - Bandwidth and filter bytes reset to zero.
// - Filter select zero gives normal margin.
// - Filter select one gives high margin.
// - Integer divider 18 bits, divides stored+1.
// - Integer divider bytes reset zero, divide one.
// - Numerator 24 bits, LSB first, resets zero.
// - Modulus 24 bits, LSB first, resets zero.
// - Zero modulus bypasses the fractional path.
`timescale 1ns/10ps
module drp_regs (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire drp_pkg::drp_addr_t s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire drp_pkg::drp_data_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire drp_pkg::drp_addr_t s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output drp_pkg::drp_data_t     s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [16:0]            loop_bandwidth,
  output logic                   high_margin_filter,
  output logic                   normal_margin_filter,
  output logic [17:0]            integer_feedback_count,
  output logic [18:0]            feedback_int_divide,
  output logic [23:0]            feedback_numerator,
  output logic [23:0]            feedback_modulus,
  output logic                   frac_enable,
  output logic [23:0]            frac_numerator_active
);
  import drp_pkg::*;

  // Decode a byte address into {hit, profile position}
  // A miss still yields an offset, so every user must gate it with the hit bit
  function automatic logic [4:0] decode(input drp_addr_t a);
    drp_idx_t w;
    drp_idx_t off;
    w = a[ADDR_W-1:2];
    off = w - IDX_BW_LO;
    decode = {(a[1:0] == 2'h0) && (w >= IDX_BW_LO) && (w <= IDX_MOD_HI), off[3:0]};
  endfunction : decode

  // Writable bits per register; reserved bits stay zero
  function automatic logic [7:0] reg_mask(input drp_loc_t loc);
    case (loc)
      LOC_BW_TOP,
      LOC_INT_TOP: reg_mask = MASK_TOP2;
      default:     reg_mask = MASK_FULL;
    endcase
  endfunction : reg_mask

  // Profile storage, one byte per register
  logic [7:0]  bytes_q [NUM_REGS];     // Register contents
  // Write channel holding
  logic        aw_full_q;              // Write address captured
  drp_addr_t   awaddr_q;               // Captured write address
  logic        w_full_q;               // Write data captured
  logic [7:0]  wbyte_q;                // Captured low data byte
  logic        wstrb0_q;               // Captured lane 0 strobe
  logic        bvalid_q;               // Write response pending
  logic [1:0]  bresp_q;                // Write response code
  // Read channel
  logic        rvalid_q;               // Read data pending
  drp_data_t   rdata_q;                // Read data word
  logic [1:0]  rresp_q;                // Read response code
  // Derived divider settings
  logic [18:0] int_div_q;              // Integer divide ratio
  logic        frac_en_q;              // Fractional path active
  logic [23:0] num_act_q;              // Numerator seen by the fractional path
  logic        wrote_any_q;            // Helper: any register written since reset

  // Decode wires
  wire [4:0]  wr_dec   = decode(awaddr_q);
  wire        wr_hit   = wr_dec[4];
  wire drp_loc_t wr_loc = wr_dec[3:0];
  wire [4:0]  rd_dec   = decode(s_axi_araddr);
  wire        rd_hit   = rd_dec[4];
  wire drp_loc_t rd_loc = rd_dec[3:0];
  // Keeps the read index inside the storage when the address misses
  wire drp_loc_t rd_idx = rd_hit ? rd_loc : LOC_BW_LO;
  // A write completes once both halves are held and no response waits
  wire        wr_fire  = ce && aw_full_q && w_full_q && !bvalid_q;
  wire        wr_en    = wr_fire && wr_hit && wstrb0_q;
  wire [7:0]  wr_val   = wbyte_q & reg_mask(wr_loc);
  wire        aw_take  = s_axi_awvalid && s_axi_awready;
  wire        w_take   = s_axi_wvalid && s_axi_wready;
  wire        ar_take  = s_axi_arvalid && s_axi_arready;
  wire [7:0]  rd_val   = bytes_q[rd_idx] & reg_mask(rd_idx);

  // Readies drop while frozen so nothing is taken without a clock enable
  // Responses come straight from flops, so the master sees settled values
  assign s_axi_awready = ce && !aw_full_q;
  assign s_axi_wready  = ce && !w_full_q;
  assign s_axi_arready = ce && !rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Field assembly straight from the byte flops
  assign loop_bandwidth = {bytes_q[LOC_BW_TOP][BW_BIT16_POS], bytes_q[LOC_BW_MID],
                           bytes_q[LOC_BW_LO]};
  assign high_margin_filter   = bytes_q[LOC_BW_TOP][FILT_SEL_POS];
  assign normal_margin_filter = !bytes_q[LOC_BW_TOP][FILT_SEL_POS];
  assign integer_feedback_count = {bytes_q[LOC_INT_TOP][1:0], bytes_q[LOC_INT_MID],
                                   bytes_q[LOC_INT_LO]};
  assign feedback_numerator = {bytes_q[LOC_NUM_HI], bytes_q[LOC_NUM_MID],
                               bytes_q[LOC_NUM_LO]};
  assign feedback_modulus   = {bytes_q[LOC_MOD_HI], bytes_q[LOC_MOD_MID],
                               bytes_q[LOC_MOD_LO]};
  assign feedback_int_divide   = int_div_q;
  assign frac_enable           = frac_en_q;
  assign frac_numerator_active = num_act_q;

  // Profile bytes; reserved bits are masked on the way in
  // A write with lane 0 strobe off still answers OKAY but stores nothing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        bytes_q[i] <= RST_BYTE;
      end
    end else if (wr_en) begin
      bytes_q[wr_loc] <= wr_val;
    end
  end

  // Write address holding; released when the response is taken
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_full_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (ce) begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (bvalid_q && s_axi_bready) begin
        aw_full_q <= 1'b0;
      end
    end
  end

  // Write data holding; only lane 0 carries a register byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_full_q <= 1'b0;
      wbyte_q  <= RST_BYTE;
      wstrb0_q <= 1'b0;
    end else if (ce) begin
      if (w_take) begin
        w_full_q <= 1'b1;
        wbyte_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (bvalid_q && s_axi_bready) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR and store nothing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read channel; data is captured on the address handshake
  // A byte written in the same cycle is not yet visible to that read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_hit ? {24'h000000, rd_val} : '0;
        rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // Divider settings follow the bytes one cycle later; the adder stays off
  // the bus path, at the cost of a one-cycle lag after each write
  // Fields are written byte by byte, so a partial modulus can enable the
  // fraction for a while; software must hold the loop during such updates
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      int_div_q <= RST_INT_DIV;
      frac_en_q <= 1'b0;
      num_act_q <= '0;
    end else if (ce) begin
      int_div_q <= {1'b0, integer_feedback_count} + INT_DIV_ONE;
      frac_en_q <= (feedback_modulus != 24'h000000);
      // Bypassed fraction feeds zero so only the integer ratio applies
      num_act_q <= (feedback_modulus != 24'h000000) ? feedback_numerator
                                                    : 24'h000000;
    end
  end

  // Helper for the reset checks below
  // It only gates assertions, so synthesis may drop it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wrote_any_q <= 1'b0;
    end else if (wr_en) begin
      wrote_any_q <= 1'b1;
    end
  end

  // Checks on the profile behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Bandwidth field: each byte write shows on the output next cycle
  bw_low_write_a: assert property (
    wr_en && wr_loc == LOC_BW_LO |=> loop_bandwidth[7:0] == $past(wbyte_q))
    else $error("Bandwidth low byte not stored");

  bw_bit16_write_a: assert property (
    wr_en && wr_loc == LOC_BW_TOP |=> loop_bandwidth[16] == $past(wbyte_q[0]))
    else $error("Bandwidth bit 16 not stored");

  // Untouched since reset, the fields keep their cleared values
  bw_reset_zero_a: assert property (
    !wrote_any_q |-> loop_bandwidth == 17'h00000 && !high_margin_filter)
    else $error("Bandwidth bytes not zero after reset");

  // Filter select: exactly one of the two margin outputs is high
  filt_select_a: assert property (
    wr_en && wr_loc == LOC_BW_TOP |=> high_margin_filter == $past(wbyte_q[1])
      && normal_margin_filter != high_margin_filter)
    else $error("Filter select not applied");

  filt_normal_a: assert property (
    wr_en && wr_loc == LOC_BW_TOP && !wbyte_q[1] |=> normal_margin_filter)
    else $error("Normal margin filter not chosen");

  // Divider trails the stored count by one enabled cycle
  int_divide_a: assert property (
    ce |=> feedback_int_divide == {1'b0, $past(integer_feedback_count)} + INT_DIV_ONE)
    else $error("Integer divide is not stored value plus one");

  int_reset_a: assert property (
    !wrote_any_q |-> integer_feedback_count == 18'h00000 && feedback_int_divide == 19'h00001)
    else $error("Integer divider not one after reset");

  // Fraction bytes land in their own lane of the field
  num_high_write_a: assert property (
    wr_en && wr_loc == LOC_NUM_HI |=> feedback_numerator[23:16] == $past(wbyte_q))
    else $error("Numerator high byte not stored");

  mod_mid_write_a: assert property (
    wr_en && wr_loc == LOC_MOD_MID |=> feedback_modulus[15:8] == $past(wbyte_q))
    else $error("Modulus middle byte not stored");

  // Zero modulus forces the fraction off and its numerator to zero
  frac_bypass_a: assert property (
    ce && feedback_modulus == 24'h000000 |=> !frac_enable && frac_numerator_active == 24'h000000)
    else $error("Zero modulus did not bypass fraction");

  frac_active_a: assert property (
    ce && feedback_modulus != 24'h000000 |=> frac_enable
      && frac_numerator_active == $past(feedback_numerator))
    else $error("Fraction not applied with nonzero modulus");

  // Bus answers: one cycle after the request, error code on a miss
  bresp_timing_a: assert property (
    wr_fire |=> s_axi_bvalid && (s_axi_bresp == RESP_OKAY) == $past(wr_hit))
    else $error("Write response not one cycle after write");

  reserved_read_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("Upper read bits not zero");

  rresp_timing_a: assert property (
    ar_take |=> s_axi_rvalid && (s_axi_rresp == RESP_OKAY) == $past(rd_hit))
    else $error("Read response not one cycle after address");

  unmapped_read_a: assert property (
    ar_take && !rd_hit |=> s_axi_rdata == 32'h00000000 && s_axi_rresp == RESP_SLVERR)
    else $error("Unmapped read did not answer with an error");

  reserved_bits_a: assert property (
    ar_take && rd_hit && (rd_loc == LOC_BW_TOP || rd_loc == LOC_INT_TOP)
      |=> s_axi_rdata[7:2] == 6'h00)
    else $error("Reserved register bits read nonzero");

  // Only one write may be in flight until its response is taken
  aw_busy_a: assert property (
    aw_take && w_take |=> !s_axi_awready && !s_axi_wready)
    else $error("Second write accepted before the response");

  // A frozen clock enable must hold every stored byte and refuse the bus
  freeze_store_a: assert property (
    !ce |=> $stable(loop_bandwidth) && $stable(high_margin_filter)
      && $stable(integer_feedback_count) && $stable(feedback_numerator)
      && $stable(feedback_modulus))
    else $error("Profile changed while clock enable low");

  freeze_ready_a: assert property (
    !ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready)
    else $error("Bus ready raised while clock enable low");

  // Unmapped writes and writes with lane 0 off leave the profile alone
  no_stray_write_a: assert property (
    !wr_en |=> $stable(loop_bandwidth) && $stable(integer_feedback_count)
      && $stable(feedback_numerator) && $stable(feedback_modulus))
    else $error("Profile changed without a mapped write");

  // Main scenarios
  cov_write_ok_c:  cover property (wr_en ##1 s_axi_bvalid && s_axi_bready);
  cov_read_ok_c:   cover property (ar_take && rd_hit ##1 s_axi_rvalid);
  cov_unmapped_c:  cover property (wr_fire && !wr_hit);
  cov_frac_on_c:   cover property (!frac_enable ##1 frac_enable);
  cov_frozen_c:    cover property (!ce && s_axi_awvalid);

endmodule : drp_regs

// *** testbench/drp_regs_tb.sv ***
// Self-checking bench for the loop profile register bank.
// Assumes drp_pkg is compiled first; the bench acts as the AXI4-Lite master.
`timescale 1ns/10ps
module drp_regs_tb;
  import drp_pkg::*;
  logic        ref_clk = 1'b0;  // 250 MHz bench clock
  logic        nrst    = 1'b0;  // Active low reset
  logic        ce      = 1'b1;  // Clock enable, high except during the frozen write test
  drp_addr_t   awaddr  = '0;    // Write address
  logic        awvalid = 1'b0;
  logic        awready;
  drp_data_t   wdata   = '0;    // Write data, byte in [7:0]
  logic [3:0]  wstrb   = 4'hF;  // Write strobes, lane 0 carries the byte
  logic        wvalid  = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready  = 1'b0;
  drp_addr_t   araddr  = '0;    // Read address
  logic        arvalid = 1'b0;
  logic        arready;
  drp_data_t   rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready  = 1'b0;
  logic [16:0] bw;
  logic        hi_m, no_m, fen;
  logic [17:0] icnt;
  logic [18:0] idiv;
  logic [23:0] num, modu, nact;
  logic [7:0]  e [NUM_REGS];    // Expected register contents
  logic [31:0] seed = 32'd88840;// Xorshift state, fixed for repeatable runs
  logic [31:0] rd_d;
  logic [1:0]  rsp;
  int          bad_count = 0;
  int          checks = 0;
  localparam int PD_HZ          = 1000000; // Phase detector rate the bench assumes
  localparam int BW_MIN_TENTHS  = 500;     // 50 Hz floor with a crystal system clock
  localparam int BW_HIGH_TENTHS = 20000;   // 2 kHz, above it high margin is advised

  drp_regs dut_u (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .loop_bandwidth(bw), .high_margin_filter(hi_m), .normal_margin_filter(no_m),
    .integer_feedback_count(icnt), .feedback_int_divide(idiv),
    .feedback_numerator(num), .feedback_modulus(modu),
    .frac_enable(fen), .frac_numerator_active(nact));

  // Free-running clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  // Xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  // Writable bits per register; reserved top bits read back zero
  function automatic logic [7:0] msk(input int i);
    return (i == 2 || i == 5) ? MASK_TOP2 : MASK_FULL;
  endfunction : msk

  // Byte address of profile register i
  function automatic drp_addr_t adr(input int i);
    drp_idx_t x;
    x = IDX_BW_LO + 14'(i);
    return {x, 2'b00};
  endfunction : adr

  // Prints the counts and the verdict, then stops
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (x !== g) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask : chk

  // A wait that never finishes is a failure of its own
  task automatic hang(input string n);
    bad_count++;
    $display("Error %s expected handshake seen none", n);
    conclude();
  endtask : hang

  // One write: address and data offered together, each dropped once taken
  task automatic wr(input drp_addr_t a, input logic [7:0] d);
    int n;
    @(posedge ref_clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {24'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang("bvalid");
    rsp = bresp;
    bready <= 1'b0;
  endtask : wr

  // One read; data and response are taken at the rvalid edge
  task automatic rd(input drp_addr_t a);
    int n;
    @(posedge ref_clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang("rvalid");
    rd_d = rdata;
    rsp  = rresp;
    rready <= 1'b0;
  endtask : rd

  // Compares every decoded output with values worked out from e[]
  task automatic outs;
    logic [17:0] c;
    logic [23:0] m;
    c = {e[5][1:0], e[4], e[3]};
    m = {e[11], e[10], e[9]};
    repeat (3) @(posedge ref_clk);
    chk("bandwidth", {15'h0, e[2][0], e[1], e[0]}, {15'h0, bw});
    chk("high_margin", {31'h0, e[2][1]}, {31'h0, hi_m});
    chk("normal_margin", {31'h0, ~e[2][1]}, {31'h0, no_m});
    chk("int_count", {14'h0, c}, {14'h0, icnt});
    chk("int_divide", {13'h0, c} + 32'h1, {13'h0, idiv});
    chk("numerator", {8'h0, e[8], e[7], e[6]}, {8'h0, num});
    chk("modulus", {8'h0, m}, {8'h0, modu});
    chk("frac_enable", {31'h0, m != 24'h0}, {31'h0, fen});
    chk("frac_active", (m != 24'h0) ? {8'h0, e[8], e[7], e[6]} : 32'h0,
        {8'h0, nact});
  endtask : outs

  // Reads every register back against e[]
  task automatic rdall;
    for (int i = 0; i < NUM_REGS; i++) begin
      rd(adr(i));
      chk("read_data", {24'h0, e[i]}, rd_d);
      chk("read_resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    end
  endtask : rdall

  // Main sequence
  initial begin
    logic [7:0]  v [NUM_REGS];
    logic [16:0] bwv;
    foreach (e[i]) e[i] = RST_BYTE;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    // Reset contents and decoded defaults
    rdall();
    outs();
    $display("test reset done");
    // Unmapped and misaligned places answer with an error and store nothing
    rd(16'h1100);
    chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped_data", 32'h0, rd_d);
    wr(16'h1134, 8'h5A);
    chk("unmapped_wresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    wr(16'h1105, 8'hA5);
    chk("misaligned_wresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    // Lane 0 strobe off: the write answers OKAY and stores nothing
    wstrb <= 4'h0;
    wr(adr(1), 8'h77);
    chk("nostrobe_wresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    wstrb <= 4'hF;
    // Clock enable low: an offered write waits untaken, then lands
    ce <= 1'b0;
    fork
      wr(adr(0), 8'h3C);
      begin
        repeat (8) @(posedge ref_clk);
        chk("frozen_awready", 32'h0, {31'h0, awready});
        chk("frozen_bvalid", 32'h0, {31'h0, bvalid});
        chk("frozen_bw", {24'h0, e[0]}, {24'h0, bw[7:0]});
        ce <= 1'b1;
      end
    join
    chk("thawed_wresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    e[0] = 8'h3C;
    rdall();
    $display("test unmapped done");
    // Round 0 all ones, round 1 zero modulus, the rest random
    for (int r = 0; r < 8; r++) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        seed = xs(seed);
        v[i] = (r == 0) ? 8'hFF : seed[7:0];
        if (r == 1 && i >= 9) v[i] = 8'h00;
      end
      // Keep the programmed bandwidth, in 0.1 Hz steps, where software may put it
      bwv = {v[2][0], v[1], v[0]};
      if (int'(bwv) < BW_MIN_TENTHS) v[1][1] = 1'b1;
      if (int'(bwv) >= PD_HZ / 5) v[2][0] = 1'b0;
      bwv = {v[2][0], v[1], v[0]};
      if (int'(bwv) > BW_HIGH_TENTHS) v[2][1] = 1'b1;
      for (int i = 0; i < NUM_REGS; i++) begin
        wr(adr(i), v[i]);
        chk("write_resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
        e[i] = v[i] & msk(i);
      end
      rdall();
      outs();
      $display("test round %0d done", r);
    end
    // Reset in mid-run brings every register and the divider back
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (e[i]) e[i] = RST_BYTE;
    rdall();
    outs();
    $display("test mid reset done");
    conclude();
  end
endmodule : drp_regs_tb
